//--- rtl/ccm_core.sv
// file: top of the compare/capture mode and interrupt routing block
//
// Added by the designer: the strobed register port.
`timescale 1ns/100ps
// What this block does
// RL1: 8-bit mode register at C1h, two bits per channel, channel 0 lowest.
// RL2: field 00 disables channel, field 10 enables compare.
// RL3: field 01 on channel 0 captures on pin edge chosen by edge select.
// RL4: field 01 on channels 1-3 captures on rising pin edge only.
// RL5: field 11 captures when software writes that channel's low byte.
// RL6: compare outputs drive pins; pin path to interrupt is then cut.
// RL7: software reading the pin always sees its actual level.
// RL8: in compare mode the compare match feeds the interrupt input.
// RL9: compare signal stays high every cycle timer equals compare value.
// RL10: in compare mode 1, shadow latch transparent while compare signal high.
// RL11: channel 0 interrupts on rising or falling compare edge per edge select.
// RL12: channels 1-3 interrupt only on compare signal rising.
// RL13: channel 0, falling edge, latch at 1: enabling compare sets flag.
// RL14: software clears flag after enabling compare, before enabling interrupt.
// RL15: software should pick falling edge with slow timer clock.
// RL16: in compare mode 1 port writes load shadow; match moves it out.
// RL17: capture copies timer into channel register the cycle after event.
// RL18: interrupt flags stay set until software writes one to clear.
module ccm_core #(
    parameter int NCH = ccm_pkg::CCM_NCH,  // channel count
    parameter int TW  = ccm_pkg::CCM_TW    // timer width
) (
    input  wire logic                 sys_clk,      // machine clock, 20 MHz
    input  wire logic                 srst,         // sync reset, active high
    input  wire logic                 clk_en,       // freezes all state when low
    input  ccm_pkg::ccm_bus_req_t     bus,          // register bus request
    output logic [7:0]                rdata,        // read data, cycle after read
    input  wire logic [TW-1:0]        timer_val,    // running timer count
    input  wire logic [NCH*TW-1:0]    cmp_val,      // compare values per channel
    input  wire logic [NCH-1:0]       pin_in,       // port pin levels (async)
    output logic [NCH-1:0]            pin_out,      // port pin drive level
    output logic [NCH-1:0]            pin_oe,       // port pin drive enable
    output logic [NCH-1:0]            cmp_match,    // internal compare signals
    output logic [NCH*TW-1:0]         cap_val,      // captured timer values
    output logic [NCH-1:0]            cap_done,     // capture happened, pulse
    output logic                      irq           // level interrupt
);
    import ccm_pkg::*;

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [7:0]        mode;
        logic [7:0]        ctrl;
        logic [NCH-1:0]    irq_flag;
        logic [NCH-1:0]    irq_mask;
        logic [NCH-1:0]    shadow;
        logic [NCH-1:0]    out_latch;
        logic [NCH-1:0]    pin_s1;
        logic [NCH-1:0]    pin_s2;
        logic [NCH-1:0]    cap_pend;
        logic [NCH-1:0]    cap_done;
        logic [NCH*TW-1:0] cap;
        logic [7:0]        rdata;
    } ccm_state_t;

    ccm_state_t     st;
    ccm_state_t     next_st;
    ccm_evt_t       evt;
    logic [NCH-1:0] match;
    logic [NCH-1:0] is_cmp;
    logic [NCH-1:0] lo_wr;
    logic [NCH-1:0] hi_wr;

    // ----------------------------------------------------------------
    // compare detection and per-channel decode
    // ----------------------------------------------------------------
    for (genvar i = 0; i < NCH; i++) begin : g_ch
        // combinational so the signal is high every equal cycle
        assign match[i]  = (timer_val == cmp_val[i*TW +: TW]);             // [RL9]
        assign is_cmp[i] = (ccm_mode_t'(st.mode[2*i +: 2]) == CCM_CMP);    // [RL2]
        assign lo_wr[i]  = bus.wr && (bus.addr == CCM_CAP_LO_BASE + 8'(i));
        assign hi_wr[i]  = bus.wr && (bus.addr == CCM_CAP_HI_BASE + 8'(i));
    end

    // edge detection and interrupt routing
    ccm_edge_unit #(
        .NCH (NCH)
    ) u_edge (
        .sys_clk   (sys_clk),
        .srst      (srst),
        .clk_en    (clk_en),
        .mode      (st.mode),
        .edge_sel  (st.ctrl[CCM_EDGE_BIT]),
        .pin_sync  (st.pin_s2),
        .cmp_match (match),
        .evt       (evt)
    );

    // ----------------------------------------------------------------
    // next-state logic
    // ----------------------------------------------------------------
    always_comb begin
        logic cm1;
        cm1     = st.ctrl[CCM_CM1_BIT];
        next_st = st;
        // two-stage pin synchroniser; only stage two is read
        next_st.pin_s1   = pin_in;
        next_st.pin_s2   = st.pin_s1;
        next_st.cap_done = '0;
        next_st.rdata    = 8'h00;

        // register writes
        if (bus.wr) begin
            case (bus.addr)
                CCM_MODE_ADDR:   next_st.mode     = bus.wdata;              // [RL1]
                CCM_CTRL_ADDR:   next_st.ctrl     = bus.wdata;
                CCM_MASK_ADDR:   next_st.irq_mask = bus.wdata[NCH-1:0];
                // clearable in any mode, write one to clear
                CCM_IRQ_ADDR:    next_st.irq_flag = st.irq_flag & ~bus.wdata[NCH-1:0]; // [RL18]
                CCM_PLATCH_ADDR: next_st.shadow   = bus.wdata[NCH-1:0];
                default:         ;
            endcase
        end

        for (int i = 0; i < NCH; i++) begin
            // software loads of the capture register itself
            if (lo_wr[i]) begin
                next_st.cap[i*TW +: 8] = bus.wdata;
            end
            if (hi_wr[i]) begin
                next_st.cap[i*TW+8 +: 8] = bus.wdata;
            end
            // output latch: mode 1 waits for a match, transparent while high
            if (is_cmp[i] && cm1) begin
                if (match[i]) begin
                    next_st.out_latch[i] = next_st.shadow[i];               // [RL10] [RL16]
                end
            end else if (is_cmp[i]) begin
                // mode 0: set on match; port writes have no effect
                if (match[i]) begin
                    next_st.out_latch[i] = 1'b1;
                end
            end else begin
                next_st.out_latch[i] = next_st.shadow[i];
            end
            // capture one cycle after the event, the write winning no race
            next_st.cap_pend[i] = evt.cap_evt[i] ||
                (lo_wr[i] && ccm_mode_t'(st.mode[2*i +: 2]) == CCM_CAP_WR); // [RL5]
            if (st.cap_pend[i]) begin
                next_st.cap[i*TW +: TW] = timer_val;                        // [RL17]
                next_st.cap_done[i]     = 1'b1;
            end
            // set beats a same-cycle clear
            if (evt.irq_evt[i]) begin
                next_st.irq_flag[i] = 1'b1;                                 // [RL8] [RL13]
            end
        end

        // register reads, answered next cycle
        if (bus.rd) begin
            case (bus.addr)
                CCM_MODE_ADDR:   next_st.rdata = st.mode;
                CCM_CTRL_ADDR:   next_st.rdata = st.ctrl;
                CCM_IRQ_ADDR:    next_st.rdata = 8'(st.irq_flag);
                CCM_MASK_ADDR:   next_st.rdata = 8'(st.irq_mask);
                CCM_PLATCH_ADDR: next_st.rdata = 8'(st.shadow);
                // the real pin level, even when it is a compare output
                CCM_PIN_ADDR:    next_st.rdata = 8'(st.pin_s2);             // [RL7]
                default: begin
                    for (int i = 0; i < NCH; i++) begin
                        if (bus.addr == CCM_CAP_LO_BASE + 8'(i)) begin
                            next_st.rdata = st.cap[i*TW +: 8];
                        end
                        if (bus.addr == CCM_CAP_HI_BASE + 8'(i)) begin
                            next_st.rdata = st.cap[i*TW+8 +: 8];
                        end
                    end
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // state register
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            st           <= '0;
            st.mode      <= CCM_MODE_RST;
            st.ctrl      <= CCM_CTRL_RST;
            st.irq_flag  <= CCM_IRQ_RST;
            st.irq_mask  <= CCM_MASK_RST;
            st.shadow    <= CCM_PLATCH_RST;
            st.out_latch <= CCM_PLATCH_RST;
            // pins idle high behind the pull-up; no false edge after reset
            st.pin_s1    <= CCM_PLATCH_RST;
            st.pin_s2    <= CCM_PLATCH_RST;
        end else if (clk_en) begin
            st <= next_st;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    // quasi-bidirectional pin: drive only a low or a compare output
    assign pin_out   = st.out_latch;                                         // [RL6]
    assign pin_oe    = is_cmp | ~st.out_latch;
    assign cmp_match = match;
    assign cap_val   = st.cap;
    assign cap_done  = st.cap_done;
    assign rdata     = st.rdata;
    assign irq       = |(st.irq_flag & st.irq_mask);
endmodule

//--- rtl/ccm_edge_unit.sv
// file: edge detection and interrupt-source routing for all channels
`timescale 1ns/100ps
module ccm_edge_unit #(
    parameter int NCH = 4                  // channel count
) (
    input  wire logic                 sys_clk,     // machine clock
    input  wire logic                 srst,        // sync reset
    input  wire logic                 clk_en,      // freezes state while low
    input  wire logic [2*NCH-1:0]     mode,        // mode fields
    input  wire logic                 edge_sel,    // channel 0 edge select
    input  wire logic [NCH-1:0]       pin_sync,    // synchronised pin levels
    input  wire logic [NCH-1:0]       cmp_match,   // compare signals
    output ccm_pkg::ccm_evt_t         evt          // event pulses
);
    import ccm_pkg::*;

    typedef struct packed {
        logic [NCH-1:0] irq_in_q;
        logic [NCH-1:0] pin_q;
    } ccm_edge_state_t;

    ccm_edge_state_t st;
    ccm_edge_state_t next_st;
    logic [NCH-1:0]  irq_in;
    logic [NCH-1:0]  irq_evt_v;
    logic [NCH-1:0]  cap_evt_v;

    // ----------------------------------------------------------------
    // per-channel source select and edge detection
    // ----------------------------------------------------------------
    for (genvar i = 0; i < NCH; i++) begin : g_ch
        logic      rise_i;
        logic      fall_i;
        logic      pin_rise;
        logic      pin_fall;
        logic      want_fall;
        ccm_mode_t m;
        assign m         = ccm_mode_t'(mode[2*i +: 2]);
        // compare mode cuts the pin off the interrupt input
        assign irq_in[i] = (m == CCM_CMP) ? cmp_match[i] : pin_sync[i];   // [RL6] [RL8]
        assign rise_i    = irq_in[i] & ~st.irq_in_q[i];
        assign fall_i    = ~irq_in[i] & st.irq_in_q[i];
        assign pin_rise  = pin_sync[i] & ~st.pin_q[i];
        assign pin_fall  = ~pin_sync[i] & st.pin_q[i];
        // only channel 0 may pick the falling edge
        assign want_fall = (i == 0) && !edge_sel;                         // [RL11] [RL12]
        // switching into compare may itself look like an edge
        assign irq_evt_v[i] = (m == CCM_CAP_WR) ? 1'b0 :
                              (m == CCM_OFF)    ? 1'b0 :
                              (want_fall ? fall_i : rise_i);               // [RL13]
        assign cap_evt_v[i] = (m == CCM_CAP_PIN) &&
                              (want_fall ? pin_fall : pin_rise);           // [RL3] [RL4]
    end

    // one driver for the whole event bundle
    assign evt = '{irq_evt: irq_evt_v, cap_evt: cap_evt_v};

    // ----------------------------------------------------------------
    // state update
    // ----------------------------------------------------------------
    always_comb begin
        next_st          = st;
        next_st.irq_in_q = irq_in;
        next_st.pin_q    = pin_sync;
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            // pins idle high behind the pull-up; avoids a false edge after reset
            st <= '1;
        end else if (clk_en) begin
            st <= next_st;
        end
    end
endmodule

//--- rtl/ccm_pkg.sv
// package: register map, field layout, reset values and types of the compare/capture mode block
package ccm_pkg;
    localparam int          CCM_NCH         = 4;
    localparam int          CCM_TW          = 16;
    localparam int          CCM_AW          = 8;
    // register offsets
    localparam logic [7:0]  CCM_MODE_ADDR   = 8'hC1;
    localparam logic [7:0]  CCM_CTRL_ADDR   = 8'hC8;
    localparam logic [7:0]  CCM_IRQ_ADDR    = 8'hC9;
    localparam logic [7:0]  CCM_MASK_ADDR   = 8'hCA;
    localparam logic [7:0]  CCM_PLATCH_ADDR = 8'hCB;
    localparam logic [7:0]  CCM_PIN_ADDR    = 8'hCC;
    localparam logic [7:0]  CCM_CAP_LO_BASE = 8'hD0;
    localparam logic [7:0]  CCM_CAP_HI_BASE = 8'hD4;
    // field positions
    localparam int          CCM_EDGE_BIT    = 0;
    localparam int          CCM_CM1_BIT     = 1;
    // reset values
    localparam logic [7:0]  CCM_MODE_RST    = 8'h00;
    localparam logic [7:0]  CCM_CTRL_RST    = 8'h00;
    localparam logic [3:0]  CCM_PLATCH_RST  = 4'hF;
    localparam logic [3:0]  CCM_IRQ_RST     = 4'h0;
    localparam logic [3:0]  CCM_MASK_RST    = 4'h0;

    typedef enum logic [1:0] {
        CCM_OFF     = 2'h0,
        CCM_CAP_PIN = 2'h1,
        CCM_CMP     = 2'h2,
        CCM_CAP_WR  = 2'h3
    } ccm_mode_t;

    // register bus request
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } ccm_bus_req_t;

    // per-channel event pulses from the edge unit
    typedef struct packed {
        logic [3:0] irq_evt;
        logic [3:0] cap_evt;
    } ccm_evt_t;
endpackage

//--- testbench/ccm_core_chk.sv
// checker: port-level assertions for the compare/capture mode block
`timescale 1ns/100ps
module ccm_core_chk
    import ccm_pkg::*;
#(
    parameter int NCH = 4,  // channel count
    parameter int TW  = 16  // timer width
) (
    input wire logic              sys_clk,    // machine clock
    input wire logic              srst,       // sync reset
    input ccm_pkg::ccm_bus_req_t  bus,        // register request
    input wire logic [7:0]        rdata,      // read data
    input wire logic [TW-1:0]     timer_val,  // timer count
    input wire logic [NCH*TW-1:0] cmp_val,    // compare values
    input wire logic [NCH-1:0]    pin_in,     // pin levels
    input wire logic [NCH-1:0]    pin_oe,     // pin drive enable
    input wire logic [NCH-1:0]    cmp_match,  // compare signals
    input wire logic [NCH*TW-1:0] cap_val,    // capture values
    input wire logic [NCH-1:0]    cap_done,   // capture pulse
    input wire logic              irq         // interrupt
);
    logic [7:0]     mode_q;
    logic [3:0]     mask_q;
    logic [NCH-1:0] exp_match;
    logic [NCH-1:0] cmp_mode;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (srst);
    // --------------------------------
    // shadows followed from bus writes
    // --------------------------------
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            mode_q <= 8'h00;
            mask_q <= 4'h0;
        end else begin
            if (bus.wr && bus.addr == CCM_MODE_ADDR) mode_q <= bus.wdata;
            if (bus.wr && bus.addr == CCM_MASK_ADDR) mask_q <= bus.wdata[3:0];
        end
    end
    // expected match and compare-mode flags per channel
    always_comb begin
        for (int i = 0; i < NCH; i++) begin
            exp_match[i] = timer_val == cmp_val[i*TW +: TW];
            cmp_mode[i]  = mode_q[2*i +: 2] == 2'b10;
        end
    end
    a_read_idle: assert property (!$past(bus.rd) |-> rdata == 8'h00)
        else $error("read data not zero outside answer");
    a_read_mode: assert property (bus.rd && bus.addr == CCM_MODE_ADDR |=> rdata == mode_q)
        else $error("mode read back wrong");
    a_match_equal: assert property (cmp_match == exp_match)
        else $error("compare signal differs from equality");
    a_compare_drive: assert property ((pin_oe & cmp_mode) == cmp_mode)
        else $error("compare channel pin not driven");
    a_write_capture: assert property (bus.wr && bus.addr == CCM_CAP_LO_BASE + 8'h03
        && mode_q[7:6] == 2'b11 |-> ##2 (cap_done[3] && cap_val[3*TW +: TW] == $past(timer_val)))
        else $error("write capture missing or wrong");
    a_pin_capture: assert property ($rose(pin_in[1]) && mode_q[3:2] == 2'b01
        |-> ##[2:8] cap_done[1])
        else $error("rising pin edge not captured");
    a_compare_irq: assert property ($rose(cmp_match[1]) && mode_q[3:2] == 2'b10
        && mask_q[1] |-> ##[1:2] irq)
        else $error("compare rise raised no interrupt");
    a_masked_quiet: assert property (mask_q == 4'h0 && $past(mask_q) == 4'h0 |-> !irq)
        else $error("interrupt high with all masked");
endmodule
bind ccm_core ccm_core_chk #(.NCH(NCH), .TW(TW)) ccm_core_chk_inst (.sys_clk(sys_clk),
    .srst(srst), .bus(bus), .rdata(rdata), .timer_val(timer_val), .cmp_val(cmp_val),
    .pin_in(pin_in), .pin_oe(pin_oe), .cmp_match(cmp_match), .cap_val(cap_val),
    .cap_done(cap_done), .irq(irq));

//--- testbench/ccm_pin_model.sv
// partner model: port pins shared by the block and outside drivers
`timescale 1ns/100ps
module ccm_pin_model (
    input  wire logic [3:0] ext_lvl,  // level driven from outside
    input  wire logic [3:0] pin_out,  // block drive level
    input  wire logic [3:0] pin_oe,   // block drive enable
    output logic      [3:0] pin_lvl   // resolved wire level
);
    // block drive wins; outside source is weak like a pulled line
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            pin_lvl[i] = pin_oe[i] ? pin_out[i] : ext_lvl[i];
        end
    end
endmodule

//--- testbench/tb_top.sv
// testbench: register-level tests of the compare/capture mode block
`timescale 1ns/100ps
module tb_top;
    import ccm_pkg::*;
    logic         sys_clk   = 1'b0;
    logic         srst      = 1'b1;
    ccm_bus_req_t bus       = '0;
    logic [15:0]  timer_val = 16'h0000;
    logic [63:0]  cmp_val   = 64'hFFFF_FFFF_FFFF_FFFF;
    logic [3:0]   ext_lvl   = 4'hF;
    logic         tmr_run   = 1'b1;
    logic         clk_en    = 1'b1;
    logic [3:0]   pin_lvl, pin_out, pin_oe, cmp_match, cap_done;
    logic [63:0]  cap_val;
    logic [7:0]   rdata;
    logic         irq;
    logic [15:0]  exp_t;
    int           errors    = 0;
    int           cmp_count = 0;
    int           n;
    int           ch;
    always #25 sys_clk = ~sys_clk;
    // timer stops on demand so a match can be held
    always @(posedge sys_clk) if (tmr_run) timer_val <= timer_val + 16'h0001;
    ccm_core ccm_core_inst (.sys_clk(sys_clk), .srst(srst), .clk_en(clk_en), .bus(bus),
        .rdata(rdata), .timer_val(timer_val), .cmp_val(cmp_val), .pin_in(pin_lvl),
        .pin_out(pin_out), .pin_oe(pin_oe), .cmp_match(cmp_match), .cap_val(cap_val),
        .cap_done(cap_done), .irq(irq));
    ccm_pin_model ccm_pin_model_inst (.ext_lvl(ext_lvl), .pin_out(pin_out),
        .pin_oe(pin_oe), .pin_lvl(pin_lvl));
    // ---------------
    // bus and helpers
    // ---------------
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // idle cycle after each strobe keeps one assignment per time step
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        bus.addr  <= a;
        bus.wdata <= v;
        bus.wr    <= 1'b1;
        @(posedge sys_clk);
        bus.wr <= 1'b0;
        @(posedge sys_clk);
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        bus.addr <= a;
        bus.rd   <= 1'b1;
        @(posedge sys_clk);
        bus.rd <= 1'b0;
        @(posedge sys_clk);
        chk({8'h00, rdata}, {8'h00, e});
    endtask
    task automatic count_done(input int c, input int cyc);
        n = 0;
        repeat (cyc) begin
            @(posedge sys_clk);
            if (cap_done[c] === 1'b1) n++;
        end
    endtask
    task automatic summarize();
        $display("errors %0d compares %0d", errors, cmp_count);
        if (errors == 0 && cmp_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    initial begin
        repeat (5000) @(posedge sys_clk);
        errors++;
        $display("[ERR] %0t watchdog expired", $time);
        summarize();
    end
    initial begin
        repeat (20) @(posedge sys_clk);
        srst <= 1'b0;
        @(posedge sys_clk);
        rd_chk(CCM_MODE_ADDR, CCM_MODE_RST);
        wr(CCM_MODE_ADDR, 8'hE4);
        rd_chk(CCM_MODE_ADDR, 8'hE4);
        rd_chk(8'h7F, 8'h00);
        ext_lvl[2] <= 1'b0;
        chk(16'(pin_oe[2]), 16'h0001);
        rd_chk(CCM_PIN_ADDR, 8'h0F);
        // capture on low-byte write, timer running
        wr(CCM_CAP_LO_BASE + 8'h03, 8'h55);
        exp_t = timer_val;
        @(posedge sys_clk);
        chk(16'(cap_done[3]), 16'h0001);
        chk(cap_val[63:48], exp_t);
        rd_chk(CCM_IRQ_ADDR, 8'h00);
        ext_lvl[1] <= 1'b0;
        count_done(1, 8);
        chk(16'(n), 16'h0000);
        wr(CCM_IRQ_ADDR, 8'h0F);
        ext_lvl[1] <= 1'b1;
        count_done(1, 8);
        chk(16'(n), 16'h0001);
        rd_chk(CCM_IRQ_ADDR, 8'h02);
        // channel 0 pin capture for both edge selections
        wr(CCM_MODE_ADDR, 8'h01);
        for (int es = 0; es < 2; es++) begin
            wr(CCM_CTRL_ADDR, 8'(es));
            ext_lvl[0] <= ~es[0];
            count_done(0, 6);
            ext_lvl[0] <= es[0];
            count_done(0, 8);
            chk(16'(n), 16'h0001);
            ext_lvl[0] <= ~es[0];
            count_done(0, 8);
            chk(16'(n), 16'h0000);
        end
        tmr_run <= 1'b0;
        ext_lvl[0] <= 1'b1;
        wr(CCM_CTRL_ADDR, 8'h00);
        count_done(0, 6);
        wr(CCM_IRQ_ADDR, 8'h0F);
        wr(CCM_MODE_ADDR, 8'h02);
        rd_chk(CCM_IRQ_ADDR, 8'h01);
        wr(CCM_IRQ_ADDR, 8'h01);
        rd_chk(CCM_IRQ_ADDR, 8'h00);
        // k 0: ch0 falling, k 1: ch0 rising, k 2: ch1 rising only
        for (int k = 0; k < 3; k++) begin
            ch = (k == 2) ? 1 : 0;
            wr(CCM_MODE_ADDR, 8'h0A);
            wr(CCM_CTRL_ADDR, (k == 1) ? 8'h01 : 8'h00);
            wr(CCM_MASK_ADDR, (k == 2) ? 8'h02 : 8'h01);
            wr(CCM_IRQ_ADDR, 8'h0F);
            cmp_val[ch*16 +: 16] <= timer_val;
            repeat (3) @(posedge sys_clk);
            chk(16'(cmp_match[ch]), 16'h0001);
            chk(16'(irq), (k == 0) ? 16'h0000 : 16'h0001);
            cmp_val[ch*16 +: 16] <= timer_val + 16'h0005;
            repeat (3) @(posedge sys_clk);
            chk(16'(irq), 16'h0001);
        end
        // compare mode 1: shadow waits for a match, then goes transparent
        wr(CCM_CTRL_ADDR, 8'h02);
        wr(CCM_PLATCH_ADDR, 8'h0E);
        chk(16'(pin_out[0]), 16'h0001);
        cmp_val[15:0] <= timer_val;
        repeat (2) @(posedge sys_clk);
        chk(16'(pin_out[0]), 16'h0000);
        wr(CCM_PLATCH_ADDR, 8'h0F);
        chk(16'(pin_out[0]), 16'h0001);
        rd_chk(CCM_PLATCH_ADDR, 8'h0F);
        wr(CCM_MASK_ADDR, 8'h00);
        repeat (2) @(posedge sys_clk);
        chk(16'(irq), 16'h0000);
        // a clear while frozen must not be taken
        clk_en <= 1'b0;
        wr(CCM_IRQ_ADDR, 8'h0F);
        clk_en <= 1'b1;
        rd_chk(CCM_IRQ_ADDR, 8'h02);
        summarize();
    end
endmodule
